// ### core/mgmt_map.svh
// Register offsets, field positions, reset values and frame bit positions of the management port
`ifndef MGMT_MAP_SVH
`define MGMT_MAP_SVH

// Register byte offsets
`define MGMT_CTRL_OFFSET   12'h000
`define MGMT_STAT_OFFSET   12'h004
`define MGMT_COUNT_OFFSET  12'h008

// Control word fields
`define FLD_MBZ            31
`define FLD_SHORT          30
`define FLD_TYPE_HI        29
`define FLD_TYPE_LO        28
`define FLD_PHY_HI         27
`define FLD_PHY_LO         23
`define FLD_REG_HI         22
`define FLD_REG_LO         18
`define FLD_TA_HI          17
`define FLD_TA_LO          16
`define FLD_DATA_HI        15
`define FLD_DATA_LO        0

// Transaction type encodings
`define TYPE_WRITE         2'h1
`define TYPE_READ          2'h2

// Status word fields
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define STAT_BADOP_BIT     2

// Reset values
`define CTRL_RESET         32'h0000_0000
`define COUNT_RESET        16'h0000

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Frame layout in link bit periods
`define PREAMBLE_BITS      6'h20
`define LAST_BIT           6'h3F
`define READ_RELEASE_BIT   6'h2E
`define READ_DATA_BIT      6'h30

`endif

// ### core/mgmt_pkg.sv
// Types shared by the management port modules
package mgmt_pkg;

   // Management control word as software sees it
   typedef struct packed {
      logic        must_be_zero_bit;
      logic        short_frame_select;
      logic [1:0]  transaction_type;
      logic [4:0]  target_phy_address;
      logic [4:0]  target_register_address;
      logic [1:0]  fixed_turnaround_code;
      logic [15:0] data;
   } mgmt_ctrl_t;

   // Serial engine states
   typedef enum logic [0:0] {
      ENG_IDLE  = 1'b0,
      ENG_SHIFT = 1'b1
   } eng_state_t;

endpackage

// ### core/mgmt_link_if.sv
// Carrier between the bus-side control and the link-side frame engine
`timescale 1ns/1ps
interface mgmt_link_if;
   logic        start_tgl;  // Toggles once per launched frame
   logic [31:0] cmd;        // Stable from launch until completion
   logic        done_tgl;   // Toggles once per finished frame
   logic [15:0] rd_data;    // Stable after done_tgl toggles

   modport ctl (output start_tgl, output cmd, input done_tgl, input rd_data);
   modport eng (input start_tgl, input cmd, output done_tgl, output rd_data);
endinterface

// ### core/bit_sync.sv
// Two-flop synchroniser for independent single-bit levels
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_check
      $error("bit_sync needs at least one bit");
   end

   // First stage feeds only the second; no reset so a reset input may pass too
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule // bit_sync

// ### core/mgmt_frame_engine.sv
// Link-side engine that shifts one management frame out on the serial pins
`timescale 1ns/1ps
`include "mgmt_map.svh"
module mgmt_frame_engine import mgmt_pkg::*; (
   input  wire logic link_clk,
   input  wire logic aresetn,
   mgmt_link_if.eng  link,
   input  wire logic mdio_in,
   output logic      mdc,
   output logic      mdio_out,
   output logic      mdio_oe
);
   logic       link_rst_n;
   logic       start_s;
   logic       mdio_s;
   logic       start_seen;
   logic       is_read;
   eng_state_t state;
   logic [5:0] bit_cnt;
   logic [15:0] rd_shift;

   // Reset, launch toggle and data pin all arrive from outside this clock
   bit_sync #(.WIDTH(3)) u_sync (
      .clk (link_clk),
      .d   ({aresetn, link.start_tgl, mdio_in}),
      .q   ({link_rst_n, start_s, mdio_s})
   );

   // Bit position n of the frame carries control bit 63-n after the preamble
   wire       start_edge  = (state == ENG_IDLE) && (start_s != start_seen);
   wire [5:0] next_bit    = bit_cnt + 6'h01;
   wire [4:0] word_idx    = ~next_bit[4:0];
   wire       in_preamble = next_bit < `PREAMBLE_BITS;
   wire       next_out    = in_preamble | link.cmd[word_idx];
   wire       released    = is_read && (next_bit >= `READ_RELEASE_BIT);
   wire       capture     = is_read && (bit_cnt >= `READ_DATA_BIT);
   wire       last_bit    = bit_cnt == `LAST_BIT;

   // Two link cycles per bit; output changes with the clock low, input taken at fall
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         state         <= ENG_IDLE;
         mdc           <= 1'b0;
         mdio_out      <= 1'b0;
         mdio_oe       <= 1'b0;
         bit_cnt       <= 6'h00;
         start_seen    <= 1'b0;
         is_read       <= 1'b0;
         rd_shift      <= 16'h0000;
         link.done_tgl <= 1'b0;
         link.rd_data  <= 16'h0000;
      end else begin
         unique case (state)
            ENG_IDLE: begin
               if (start_edge) begin
                  start_seen <= start_s;
                  is_read    <= link.cmd[`FLD_TYPE_HI:`FLD_TYPE_LO] == `TYPE_READ;
                  bit_cnt    <= 6'h00;
                  mdio_out   <= 1'b1;
                  mdio_oe    <= 1'b1;
                  state      <= ENG_SHIFT;
               end
            end
            ENG_SHIFT: begin
               mdc <= ~mdc;
               if (mdc) begin
                  if (capture) begin
                     rd_shift <= {rd_shift[14:0], mdio_s};
                  end
                  if (last_bit) begin
                     state         <= ENG_IDLE;
                     mdio_oe       <= 1'b0;
                     mdio_out      <= 1'b0;
                     link.rd_data  <= {rd_shift[14:0], mdio_s};
                     link.done_tgl <= ~link.done_tgl;
                  end else begin
                     bit_cnt  <= next_bit;
                     mdio_out <= next_out;
                     mdio_oe  <= !released;
                  end
               end
            end
         endcase
      end
   end

   sequence frame_start_s;
      (state == ENG_SHIFT) && mdio_oe && mdio_out && (bit_cnt == 6'h00);
   endsequence

   property launch_p;
      @(posedge link_clk) disable iff (!link_rst_n) start_edge |=> frame_start_s;
   endproperty

   frame_launch_a: assert property (launch_p)
      else $error("frame did not start after launch");

   short_frame_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (state == ENG_SHIFT) && (bit_cnt == 6'h21) |-> mdio_out == link.cmd[`FLD_SHORT])
      else $error("frame select bit wrong on the pin");

   type_bits_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (state == ENG_SHIFT) && (bit_cnt == 6'h22) && !mdc
      |-> mdio_out == link.cmd[`FLD_TYPE_HI] ##2 mdio_out == link.cmd[`FLD_TYPE_LO])
      else $error("transaction type bits wrong on the pin");

   read_release_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (state == ENG_SHIFT) && is_read && (bit_cnt >= `READ_RELEASE_BIT) |-> !mdio_oe)
      else $error("pin driven during read turnaround or data");

   phy_addr_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (state == ENG_SHIFT) && (bit_cnt == 6'h24) && !mdc
      |-> mdio_out == link.cmd[`FLD_PHY_HI] ##8 mdio_out == link.cmd[`FLD_PHY_LO])
      else $error("phy address wrong on the pin");

   reg_addr_a: assert property (
      @(posedge link_clk) disable iff (!link_rst_n)
      (state == ENG_SHIFT) && (bit_cnt == 6'h29) && !mdc
      |-> mdio_out == link.cmd[`FLD_REG_HI] ##8 mdio_out == link.cmd[`FLD_REG_LO])
      else $error("register address wrong on the pin");
endmodule // mgmt_frame_engine

// ### core/phy_management_frame_control.sv
// PHY management port: AXI4-Lite control register and frame launch toward the link
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "mgmt_map.svh"
module phy_management_frame_control import mgmt_pkg::*; #(
   parameter int ADDR_WIDTH = 12
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  link_clk,
   input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       mdc,
   input  wire logic                  mdio_in,
   output logic                       mdio_out,
   output logic                       mdio_oe
);
   localparam logic [ADDR_WIDTH-1:0] CTRL_ADDR  = ADDR_WIDTH'(`MGMT_CTRL_OFFSET);
   localparam logic [ADDR_WIDTH-1:0] STAT_ADDR  = ADDR_WIDTH'(`MGMT_STAT_OFFSET);
   localparam logic [ADDR_WIDTH-1:0] COUNT_ADDR = ADDR_WIDTH'(`MGMT_COUNT_OFFSET);

   if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_check
      $error("ADDR_WIDTH must hold the register offsets and fit the bus");
   end

   mgmt_link_if link ();

   mgmt_ctrl_t              ctrl;
   logic                    busy;
   logic                    done_flag;
   logic                    bad_op;
   logic                    done_s;
   logic                    done_seen;
   logic [15:0]             frame_count;
   logic [ADDR_WIDTH-1:0]   aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    aw_full;
   logic                    w_full;

   // Completion toggle comes from the link clock
   bit_sync #(.WIDTH(1)) u_done_sync (
      .clk (aclk),
      .d   (link.done_tgl),
      .q   (done_s)
   );

   // Serial side runs entirely on the link clock
   mgmt_frame_engine u_engine (
      .link_clk (link_clk),
      .aresetn  (aresetn),
      .link     (link.eng),
      .mdio_in  (mdio_in),
      .mdc      (mdc),
      .mdio_out (mdio_out),
      .mdio_oe  (mdio_oe)
   );

   // The word is only changed while idle, so the engine may sample it freely
   assign link.cmd = ctrl;

   // Write decode once address and data are both held
   wire wr_fire  = aw_full && w_full && !s_axi_bvalid;
   wire aw_ctrl  = aw_addr[ADDR_WIDTH-1:2] == CTRL_ADDR[ADDR_WIDTH-1:2];
   wire wr_ctrl  = wr_fire && aw_ctrl;
   wire wr_ok    = wr_ctrl && !busy;

   // Byte lanes merge new data over the held word
   logic [31:0] merged;
   for (genvar lane = 0; lane < 4; lane++) begin : g_lane
      assign merged[8*lane +: 8] = w_strb[lane] ? w_data[8*lane +: 8] : ctrl[8*lane +: 8];
   end

   wire [1:0] new_type = merged[`FLD_TYPE_HI:`FLD_TYPE_LO];
   wire       op_ok    = (new_type == `TYPE_WRITE) || (new_type == `TYPE_READ);
   wire       launch   = wr_ok && op_ok;
   wire       done_edge = done_s != done_seen;
   wire       was_read = ctrl.transaction_type == `TYPE_READ;

   // Read decode
   wire ar_ctrl  = s_axi_araddr[ADDR_WIDTH-1:2] == CTRL_ADDR[ADDR_WIDTH-1:2];
   wire ar_stat  = s_axi_araddr[ADDR_WIDTH-1:2] == STAT_ADDR[ADDR_WIDTH-1:2];
   wire ar_count = s_axi_araddr[ADDR_WIDTH-1:2] == COUNT_ADDR[ADDR_WIDTH-1:2];
   wire ar_hit   = ar_ctrl || ar_stat || ar_count;

   wire [31:0] status_word = (32'(busy) << `STAT_BUSY_BIT)
                           | (32'(done_flag) << `STAT_DONE_BIT)
                           | (32'(bad_op) << `STAT_BADOP_BIT);
   wire [31:0] rd_word     = ar_ctrl  ? ctrl
                           : ar_stat  ? status_word
                           : ar_count ? {16'h0000, frame_count}
                           : 32'h0000_0000;

   // Write address and data are taken in either order and held until the answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_full       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_full       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control word, launch toggle and completion; a write while busy is refused
   // rather than queued, because the engine reads the word during the whole frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl           <= `CTRL_RESET;
         busy           <= 1'b0;
         done_flag      <= 1'b0;
         bad_op         <= 1'b0;
         done_seen      <= 1'b0;
         frame_count    <= `COUNT_RESET;
         link.start_tgl <= 1'b0;
      end else begin
         if (done_edge) begin
            done_seen   <= done_s;
            busy        <= 1'b0;
            done_flag   <= 1'b1;
            frame_count <= frame_count + 16'h0001;
            if (was_read) begin
               ctrl.data <= link.rd_data;
            end
         end
         if (wr_ok) begin
            ctrl      <= merged;
            bad_op    <= !op_ok;
            done_flag <= 1'b0;
         end
         if (launch) begin
            busy           <= 1'b1;
            link.start_tgl <= ~link.start_tgl;
         end
      end
   end

   // One read at a time; the answer follows the address by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= ar_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   sequence launched_s;
      busy && (link.start_tgl != $past(link.start_tgl));
   endsequence

   property launch_on_write_p;
      @(posedge aclk) disable iff (!aresetn) launch |=> launched_s;
   endproperty

   launch_on_write_a: assert property (launch_on_write_p)
      else $error("valid control write did not launch a frame");

   bad_type_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_ok && !op_ok |=> !busy && bad_op && $stable(link.start_tgl))
      else $error("reserved transaction type launched a frame");

   read_back_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      done_edge && was_read |=> ctrl.data == $past(link.rd_data))
      else $error("read data not loaded into the control word");

   word_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      busy && !done_edge |=> $stable(ctrl[31:16]) && busy)
      else $error("frame fields changed while a frame was running");

   busy_refuse_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_ctrl && busy |=> s_axi_bvalid && (s_axi_bresp == `RESP_SLVERR))
      else $error("write during a frame was not refused");
endmodule // phy_management_frame_control

// ### sim/phy_model.sv
// Behavioural PHY that answers management frames on the serial link
`timescale 1ns/1ps
module phy_model (
   input  wire logic        mdc,
   input  wire logic        mdio_wire,
   input  wire logic        host_oe,
   input  wire logic [15:0] reply,
   input  wire logic        slow,
   output logic             phy_oe,
   output logic             phy_out,
   output logic [63:0]      frame,
   output int               frames,
   output int               clash
);
   logic [63:0] sh = '0;
   int          cnt = 0;
   logic        is_read = 1'b0;

   initial begin
      phy_oe = 1'b0;
      phy_out = 1'b0;
      frame = '0;
      frames = 0;
      clash = 0;
   end

   // Sample the wire at each rising clock edge; a frame opens on the host driving
   always @(posedge mdc) begin
      if (cnt > 0 || host_oe) begin
         sh = {sh[62:0], mdio_wire};
         if (host_oe && phy_oe)
            clash++;
         if (cnt == 35)
            is_read = (sh[1:0] == 2'b10);
         cnt++;
         if (cnt == 64) begin
            frame = sh;
            frames++;
            cnt = 0;
            is_read = 1'b0;
         end
      end
   end

   // Present the next read bit after each rising edge so it stands at the host's
   // sample on the following fall; slow mode drives late but still before that fall
   always @(posedge mdc) begin
      #(slow ? 10 : 1);
      phy_oe = is_read && cnt >= 47;
      phy_out = (cnt >= 48) ? reply[63 - cnt] : 1'b0;
   end
endmodule  // phy_model

// ### sim/testbench.sv
// Self-checking bench for the PHY management control port
`timescale 1ns/1ps
`include "mgmt_map.svh"
module testbench import mgmt_pkg::*;;
   logic        aclk = 1'b0;
   logic        link_clk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, mdc, mdio_out, mdio_oe;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] phy_reply = 16'h0;
   logic        phy_slow = 1'b0;
   logic        phy_oe, phy_out;
   logic [63:0] frame;
   int          frames, clash;
   int          failures = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // Pulled-up data line: released by both ends it reads high
   wire         mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

   always #4 aclk = ~aclk;
   always #7.5 link_clk = ~link_clk;

   phy_management_frame_control dut (.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

   phy_model phy (.mdc(mdc), .mdio_wire(mdio_in), .host_oe(mdio_oe), .reply(phy_reply),
      .slow(phy_slow), .phy_oe(phy_oe), .phy_out(phy_out), .frame(frame), .frames(frames),
      .clash(clash));

   task automatic finish_test;
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // A hung handshake ends the run here
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Address and data offered together, each released when taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      bit fin;
      fin = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!fin) begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            fin = 1;
         end
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      bit fin;
      fin = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!fin) begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            fin = 1;
         end
      end
   endtask

   task automatic wait_idle(output logic [31:0] s);
      logic [1:0] r;
      do
         axi_read(`MGMT_STAT_OFFSET, s, r);
      while (s[`STAT_BUSY_BIT] !== 1'b0);
   endtask

   function automatic mgmt_ctrl_t mk(logic sel, logic [1:0] ty, logic [4:0] phy_a,
                                     logic [4:0] reg_a, logic [15:0] d);
      mk = '{must_be_zero_bit: 1'b0, short_frame_select: sel, transaction_type: ty,
             target_phy_address: phy_a, target_register_address: reg_a,
             fixed_turnaround_code: 2'b10, data: d};
   endfunction

   // Launch one frame and judge the wire, the readback and the counter
   task automatic run_frame(input logic [31:0] w, input logic [15:0] reply,
                            input logic slow_mode, input int exp_n);
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] low;
      low = (w[29:28] == `TYPE_READ) ? reply : w[15:0];
      phy_reply = reply;
      phy_slow = slow_mode;
      axi_write(`MGMT_CTRL_OFFSET, w, r);
      check("launch resp", r, `RESP_OKAY);
      wait_idle(d);
      check("status after frame", d[2:0], 3'b010);
      check("frame head", frame[63:18], {32'hFFFF_FFFF, w[31:18]});
      check("frame low", frame[15:0], low);
      check("bus clash", clash, 0);
      check("frames seen", frames, exp_n);
      axi_read(`MGMT_CTRL_OFFSET, d, r);
      check("ctrl readback", d, {w[31:16], low});
      axi_read(`MGMT_COUNT_OFFSET, d, r);
      check("frame counter", d, exp_n);
      check("counter resp", r, `RESP_OKAY);
      check("idle pins", {mdc, mdio_oe}, 2'b00);
   endtask

   task automatic t_reset_values;
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(`MGMT_CTRL_OFFSET, d, r);
      check("ctrl reset", d, `CTRL_RESET);
      axi_read(`MGMT_COUNT_OFFSET, d, r);
      check("count reset", d, 32'h0);
      axi_read(12'h00C, d, r);
      check("unmapped resp", r, `RESP_SLVERR);
      check("unmapped data", d, 32'h0);
      check("idle pins", {mdc, mdio_oe}, 2'b00);
   endtask

   task automatic t_short_write;
      run_frame(mk(1'b1, `TYPE_WRITE, 5'h1F, 5'h01, 16'hA5C3), 16'h0, 1'b0, 1);
   endtask

   // Long form read with a late-driving PHY
   task automatic t_long_read;
      run_frame(mk(1'b0, `TYPE_READ, 5'h00, 5'h1E, 16'h0), 16'h3C96, 1'b1, 2);
   endtask

   task automatic t_reserved_types;
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 4; i += 3) begin
         axi_write(`MGMT_CTRL_OFFSET, mk(1'b1, 2'(i), 5'h03, 5'h04, 16'h1234), r);
         check("reserved resp", r, `RESP_OKAY);
         axi_read(`MGMT_STAT_OFFSET, d, r);
         check("reserved status", d[2:0], 3'b100);
         axi_read(`MGMT_COUNT_OFFSET, d, r);
         check("no frame", d, 32'h2);
      end
   endtask

   // A second launch while busy is refused and leaves the word alone
   task automatic t_busy_refusal;
      logic [31:0] d;
      logic [31:0] w1;
      logic [1:0]  r;
      w1 = mk(1'b1, `TYPE_WRITE, 5'h11, 5'h02, 16'h0F0F);
      axi_write(`MGMT_CTRL_OFFSET, w1, r);
      check("first resp", r, `RESP_OKAY);
      axi_write(`MGMT_CTRL_OFFSET, mk(1'b0, `TYPE_READ, 5'h05, 5'h06, 16'hFFFF), r);
      check("busy resp", r, `RESP_SLVERR);
      axi_write(`MGMT_STAT_OFFSET, 32'h0000_0007, r);
      check("status write resp", r, `RESP_SLVERR);
      wait_idle(d);
      check("single frame", frames, 3);
      check("frame kept", frame[31:0], w1);
      axi_read(`MGMT_CTRL_OFFSET, d, r);
      check("ctrl kept", d, w1);
   endtask

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      t_reset_values();
      t_short_write();
      t_long_read();
      t_reserved_types();
      t_busy_refusal();
      finish_test();
   end
endmodule  // testbench
